// ### include/erase_suspend_pkg.sv
// Package: register map, field positions and types for erase-suspend control
package erase_suspend_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] mode_offset = 8'h04;
    localparam logic [7:0] state_offset = 8'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int suspend_enable_bit = 0;
    localparam int suspend_request_bit = 1;
    localparam int erase_status_bit = 6;
    localparam int cpu_rewrite_enable_bit = 0;
    localparam int mode1_select_bit = 1;
    localparam int busy_bit = 0;
    localparam int suspended_bit = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic rst_suspend_enable = 1'b0;
    localparam logic rst_suspend_request = 1'b0;
    localparam logic rst_erase_status = 1'b1;
    localparam logic rst_cpu_rewrite_enable = 1'b0;
    localparam logic rst_mode1_select = 1'b0;

    // ------------------------------------------------------------------
    // Bus constants
    // ------------------------------------------------------------------
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [1:0] htrans_seq = 2'h3;
    localparam logic [2:0] hsize_word = 3'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        st_idle,
        st_erasing,
        st_suspended
    } erase_state_type;

    typedef struct packed {
        logic start;
        logic done;
        logic irq;
    } erase_in_type;

    typedef struct packed {
        logic run;
        logic halt;
        logic erase_status;
    } erase_out_type;

endpackage : erase_suspend_pkg

// ### verilog/erase_suspend_ctrl.sv
// Top: erase-suspend control register and sequencer state, AHB-Lite slave
`timescale 1ns/1ns

module erase_suspend_ctrl
    import erase_suspend_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire erase_in_type erase_in,
    output erase_out_type erase_out
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_n;

    reset_sync u_reset_sync (
        .clk(clk),
        .arst_n(arst_n),
        .rst_n(rst_n)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic suspend_enable;
        logic suspend_request;
        logic cpu_rewrite_enable;
        logic mode1_select;
        erase_state_type state;
        erase_out_type out;
        logic bus_ready;
        logic bus_resp;
    } top_state_type;

    top_state_type cur_ff;
    top_state_type nxt_cur;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    function automatic logic valid_access(input logic sel, input logic [1:0] tr,
                                          input logic rdy);
        valid_access = sel && rdy && (tr == htrans_nonseq || tr == htrans_seq);
    endfunction : valid_access

    // ------------------------------------------------------------------
    // Next-state signals
    // ------------------------------------------------------------------
    logic take;
    logic mode1_active;
    logic sw_suspend;
    logic sw_resume;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        take = valid_access(hsel, htrans, hready);
        mode1_active = cur_ff.cpu_rewrite_enable && cur_ff.mode1_select;
        sw_suspend = 1'b0;
        sw_resume = 1'b0;

        // ------------------------------------------------------------------
        // Data phase of a write
        // ------------------------------------------------------------------
        nxt_cur.wr_pend = take && hwrite;
        nxt_cur.wr_addr = haddr;
        if (cur_ff.wr_pend) begin
            case (cur_ff.wr_addr)
                ctrl_offset: begin
                    nxt_cur.suspend_enable = hwdata[suspend_enable_bit];
                    if (hwdata[suspend_request_bit] && !mode1_active) begin
                        sw_suspend = 1'b1;
                    end
                    // Clearing the request bit also resumes
                    if (!hwdata[suspend_request_bit]) begin
                        sw_resume = 1'b1;
                    end
                end
                mode_offset: begin
                    nxt_cur.cpu_rewrite_enable = hwdata[cpu_rewrite_enable_bit];
                    if (cur_ff.cpu_rewrite_enable) begin
                        nxt_cur.mode1_select = hwdata[mode1_select_bit];
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------------
        // Erase sequencer
        // ------------------------------------------------------------------
        case (cur_ff.state)
            st_idle: begin
                nxt_cur.suspend_request = 1'b0;
                if (erase_in.start) begin
                    nxt_cur.state = st_erasing;
                end
            end
            st_erasing: begin
                // Completion wins over a same-cycle suspend
                if (erase_in.done) begin
                    nxt_cur.state = st_idle;
                    nxt_cur.suspend_request = 1'b0;
                end else if (cur_ff.suspend_enable) begin
                    if (sw_suspend) begin
                        nxt_cur.suspend_request = 1'b1;
                        nxt_cur.state = st_suspended;
                    end else if (mode1_active && erase_in.irq) begin
                        nxt_cur.suspend_request = 1'b1;
                        nxt_cur.state = st_suspended;
                    end
                end
            end
            st_suspended: begin
                if (sw_resume) begin
                    nxt_cur.suspend_request = 1'b0;
                    nxt_cur.state = st_erasing;
                end
            end
            default: begin
                nxt_cur.state = st_idle;
            end
        endcase

        // ------------------------------------------------------------------
        // Status outputs
        // ------------------------------------------------------------------
        nxt_cur.out.run = (nxt_cur.state == st_erasing);
        nxt_cur.out.halt = (nxt_cur.state == st_suspended);
        nxt_cur.out.erase_status = (nxt_cur.state != st_erasing);

        // ------------------------------------------------------------------
        // Bus response: zero wait states, always OKAY
        // ------------------------------------------------------------------
        nxt_cur.bus_ready = 1'b1;
        nxt_cur.bus_resp = 1'b0;

        // ------------------------------------------------------------------
        // Read data registered in the address phase
        // ------------------------------------------------------------------
        nxt_cur.rdata = 32'h0000_0000;
        if (take && !hwrite) begin
            case (haddr)
                ctrl_offset: begin
                    nxt_cur.rdata[suspend_enable_bit] = nxt_cur.suspend_enable;
                    nxt_cur.rdata[suspend_request_bit] = nxt_cur.suspend_request;
                    nxt_cur.rdata[erase_status_bit] = nxt_cur.out.erase_status;
                end
                mode_offset: begin
                    nxt_cur.rdata[cpu_rewrite_enable_bit] = nxt_cur.cpu_rewrite_enable;
                    nxt_cur.rdata[mode1_select_bit] = nxt_cur.mode1_select;
                end
                state_offset: begin
                    nxt_cur.rdata[busy_bit] = nxt_cur.out.run;
                    nxt_cur.rdata[suspended_bit] = nxt_cur.out.halt;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{
                wr_pend: 1'b0,
                wr_addr: 8'h00,
                rdata: 32'h0000_0000,
                suspend_enable: rst_suspend_enable,
                suspend_request: rst_suspend_request,
                cpu_rewrite_enable: rst_cpu_rewrite_enable,
                mode1_select: rst_mode1_select,
                state: st_idle,
                out: '{run: 1'b0, halt: 1'b0, erase_status: rst_erase_status},
                bus_ready: 1'b1,
                bus_resp: 1'b0
            };
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata = cur_ff.rdata;
    assign hreadyout = cur_ff.bus_ready;
    assign hresp = cur_ff.bus_resp;
    assign erase_out = cur_ff.out;

endmodule : erase_suspend_ctrl

// ### verilog/reset_sync.sv
// Reset synchroniser: async assert, two-flop release
`timescale 1ns/1ns

module reset_sync (
    input wire logic clk,
    input wire logic arst_n,
    output logic rst_n
);

    logic [1:0] sync_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_ff <= 2'h0;
        end else begin
            sync_ff <= {sync_ff[0], 1'b1};
        end
    end

    assign rst_n = sync_ff[1];

endmodule : reset_sync

// ### sim/erase_suspend_assertions.sv
// Checker: port-level assertions for erase-suspend control
`timescale 1ns/1ns
module erase_suspend_checker import erase_suspend_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire erase_in_type erase_in,
    input wire erase_out_type erase_out
);
    logic wr_ctrl_ff;
    logic rd_ff;
    // Data phase markers for ctrl writes and reads
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ctrl_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else begin
            wr_ctrl_ff <= hsel && hready && htrans[1] && hwrite && haddr == ctrl_offset;
            rd_ff <= hsel && hready && htrans[1] && !hwrite;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_run_st; erase_out.run |-> !erase_out.erase_status; endproperty
    a_run_st: assert property (p_run_st) else $error("status high while erasing");
    property p_halt_st; erase_out.halt |-> erase_out.erase_status; endproperty
    a_halt_st: assert property (p_halt_st) else $error("status low while suspended");
    property p_excl; !(erase_out.run && erase_out.halt); endproperty
    a_excl: assert property (p_excl) else $error("run and halt together");
    property p_src; $rose(erase_out.halt) |-> $past(erase_out.run); endproperty
    a_src: assert property (p_src) else $error("suspend without erase");
    property p_cause;
        $rose(erase_out.halt) |-> $past(erase_in.irq) || $past(wr_ctrl_ff && hwdata[1]);
    endproperty
    a_cause: assert property (p_cause) else $error("suspend without request");
    property p_done; erase_out.run && erase_in.done |=> !erase_out.run && !erase_out.halt;
    endproperty
    a_done: assert property (p_done) else $error("erase did not complete");
    property p_resume; $fell(erase_out.halt) |-> erase_out.run; endproperty
    a_resume: assert property (p_resume) else $error("resume lost the erase");
    property p_rdata; hrdata != 32'h0 |-> rd_ff && hreadyout && !hresp; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside data phase");
    c_halt: cover property ($rose(erase_out.halt));
    c_done: cover property (erase_out.run && erase_in.done);
    c_resume: cover property ($fell(erase_out.halt));
endmodule : erase_suspend_checker

bind erase_suspend_ctrl erase_suspend_checker chk_i (.clk(clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .erase_in(erase_in), .erase_out(erase_out));

// ### sim/erase_suspend_ctrl_tb_top.sv
// Testbench: erase-suspend control driven over AHB-Lite
`timescale 1ns/1ns
module erase_suspend_ctrl_tb_top import erase_suspend_pkg::*;;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_type;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd_s, q;
    logic hreadyout, hresp;
    erase_in_type ein = '0;
    erase_out_type eout;
    int n_fail = 0;
    int comparisons = 0;
    row_type rows [8] = '{'{ctrl_offset, 32'h40, 32'h40}, '{ctrl_offset, 32'h01, 32'h41},
        '{mode_offset, 32'h02, 32'h00}, '{mode_offset, 32'h01, 32'h01},
        '{mode_offset, 32'h03, 32'h03}, '{mode_offset, 32'h01, 32'h01},
        '{8'h0c, 32'hff, 32'h00}, '{state_offset, 32'h03, 32'h00}};

    erase_suspend_ctrl uut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize_word), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .erase_in(ein), .erase_out(eout));

    initial forever #25 clk = ~clk;
    // Read data settled mid data phase
    always @(negedge clk) rd_s = hrdata;

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= htrans_nonseq;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = rd_s;
    endtask : bus

    task automatic kick(input erase_in_type v);
        ein <= v;
        @(posedge clk);
        ein <= '0;
        @(posedge clk);
    endtask : kick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, ctrl_offset, 32'h0);
        chk(q, 32'h40);
        bus(1'b0, mode_offset, 32'h0);
        chk(q, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            chk(q, rows[i].e);
        end
        kick(3'b100);
        bus(1'b0, state_offset, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, ctrl_offset, 32'h3);
        bus(1'b0, ctrl_offset, 32'h0);
        chk(q, 32'h43);
        bus(1'b1, ctrl_offset, 32'h1);
        bus(1'b0, ctrl_offset, 32'h0);
        chk(q, 32'h1);
        kick(3'b010);
        bus(1'b1, ctrl_offset, 32'h0);
        kick(3'b100);
        bus(1'b1, ctrl_offset, 32'h2);
        kick(3'b001);
        bus(1'b0, state_offset, 32'h0);
        chk(q, 32'h1);
        kick(3'b010);
        bus(1'b0, state_offset, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, mode_offset, 32'h3);
        bus(1'b1, ctrl_offset, 32'h1);
        kick(3'b100);
        kick(3'b001);
        bus(1'b0, ctrl_offset, 32'h0);
        chk(q, 32'h43);
        bus(1'b1, ctrl_offset, 32'h1);
        bus(1'b0, state_offset, 32'h0);
        chk(q, 32'h1);
        arst_n <= 1'b0;
        @(posedge clk);
        chk(32'(eout), 32'h1);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, ctrl_offset, 32'h0);
        chk(q, 32'h40);
        bus(1'b0, mode_offset, 32'h0);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule : erase_suspend_ctrl_tb_top
